// >>> design/srr_pkg.sv
// Constants for the shift, rotate and bit reverse unit.
// Assumes a 32-bit data path and a 9-bit register index.
package srr_pkg;

    localparam int DW = 32;
    localparam int AW = 12;
    localparam int RW = 9;
    localparam int SW = 5;

    // Byte offsets of the control registers.
    localparam logic [AW-1:0] OFF_INSTR  = 12'h000;
    localparam logic [AW-1:0] OFF_FLAGS  = 12'h004;
    localparam logic [AW-1:0] OFF_RESULT = 12'h008;
    localparam logic [AW-1:0] OFF_STATUS = 12'h00C;
    // Register memory window: 0x800 + 4 * index.
    localparam int MEM_SEL_BIT = 11;
    localparam int MEM_IDX_LO  = 2;

    // Flag and status bit positions.
    localparam int FLAG_Z  = 0;
    localparam int FLAG_C  = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_ILL  = 1;
    localparam int ST_SKIP = 2;
    localparam int ST_WROTE = 3;

    // Instruction word fields.
    localparam int OPC_HI  = 31;
    localparam int OPC_LO  = 26;
    localparam int EFF_Z   = 25;
    localparam int EFF_C   = 24;
    localparam int EFF_R   = 23;
    localparam int EFF_I   = 22;
    localparam int COND_HI = 21;
    localparam int COND_LO = 18;
    localparam int DST_HI  = 17;
    localparam int DST_LO  = 9;
    localparam int SRC_HI  = 8;
    localparam int SRC_LO  = 0;

    localparam logic [5:0] OPC_ROT_RIGHT    = 6'h08;
    localparam logic [5:0] OPC_ROT_LEFT     = 6'h09;
    localparam logic [5:0] OPC_ASHIFT_RIGHT = 6'h0E;
    localparam logic [5:0] OPC_BIT_REVERSE  = 6'h0F;
    localparam logic [3:0] COND_ALWAYS = 4'hF;

    localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
    localparam logic          RST_FLAG = 1'b0;

    // Cycles from instruction write to bus release.
    localparam int EXEC_CYCLES = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_EXEC = 2'b10
    } srr_state_e;

endpackage : srr_pkg

// >>> design/srr_rotator.sv
// Barrel rotator, left or right by a 5-bit amount.
// Assumes the amount is below the width.
module srr_rotator
    import srr_pkg::*;
#(
    parameter int W = DW
) (
    input  wire logic [W-1:0]  val_i,   // Value to rotate.
    input  wire logic [SW-1:0] amt_i,   // Rotate amount.
    input  wire logic          left_i,  // 1 rotates left.
    output logic      [W-1:0]  res_o    // Rotated value.
);

    wire [2*W-1:0] dbl_l = {val_i, val_i} << amt_i;
    wire [2*W-1:0] dbl_r = {val_i, val_i} >> amt_i;

    // Bits leaving one end re-enter at the other end.
    assign res_o = left_i ? dbl_l[2*W-1:W] : dbl_r[W-1:0];

endmodule // srr_rotator

// >>> design/srr_bit_reverse.sv
// Bit reverse of the low W - amount bits with zero fill above.
// Assumes the amount is below the width.
module srr_bit_reverse
    import srr_pkg::*;
#(
    parameter int W = DW
) (
    input  wire logic [W-1:0]  val_i,  // Value to reverse.
    input  wire logic [SW-1:0] amt_i,  // Count of cleared MSBs.
    output logic      [W-1:0]  res_o   // Reversed value.
);

    logic [W-1:0] flipped;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            flipped[i] = val_i[W-1-i];
        end
    end

    // Shifting the full reversal right drops the high input bits.
    assign res_o = flipped >> amt_i;

endmodule // srr_bit_reverse

// >>> design/srr_unit.sv
// Shift, rotate and bit reverse slice with its register memory.
// Assumes an Avalon-MM master with waitrequest on one clock.
//
// Design decisions made here: register access over Avalon-MM and the address map.

module srr_unit
    import srr_pkg::*;
#(
    parameter int DEPTH = 512
) (
    input  wire logic          CLK_I,              // Clock, 250 MHz.
    input  wire logic          NRST_I,             // Sync reset, low.
    input  wire logic [AW-1:0] AVS_ADDRESS_I,      // Byte address.
    input  wire logic          AVS_READ_I,         // Read request.
    input  wire logic          AVS_WRITE_I,        // Write request.
    input  wire logic [DW-1:0] AVS_WRITEDATA_I,    // Write data.
    input  wire logic [3:0]    AVS_BYTEENABLE_I,   // Byte lanes.
    output logic      [DW-1:0] AVS_READDATA_O,     // Read data.
    output logic               AVS_WAITREQUEST_O,  // Stall.
    output logic               ZERO_FLAG_O,        // Z flag.
    output logic               CARRY_FLAG_O,       // C flag.
    output logic               BUSY_O              // Executing.
);

    // Register memory addressed by the destination and source fields.
    logic [DW-1:0] mem [DEPTH];

    srr_state_e    state_reg;
    srr_state_e    state_next;
    logic          wait_reg;
    logic          wait_next;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;
    logic [DW-1:0] instr_reg;
    logic [DW-1:0] instr_next;
    logic [DW-1:0] dval_reg;
    logic [DW-1:0] sval_reg;
    logic [DW-1:0] result_reg;
    logic [DW-1:0] result_next;
    logic          z_reg;
    logic          z_next;
    logic          c_reg;
    logic          c_next;
    logic          ill_reg;
    logic          skip_reg;
    logic          wrote_reg;
    logic          busy_reg;

    // Bus decode.
    wire bus_req    = AVS_READ_I | AVS_WRITE_I;
    wire idle       = (state_reg == ST_IDLE);
    wire bus_accept = bus_req & wait_reg & idle;
    wire bus_commit = bus_req & ~wait_reg;
    wire wr_commit  = bus_commit & AVS_WRITE_I;

    wire sel_mem    = AVS_ADDRESS_I[MEM_SEL_BIT];
    wire sel_instr  = ~sel_mem & (AVS_ADDRESS_I == OFF_INSTR);
    wire sel_flags  = ~sel_mem & (AVS_ADDRESS_I == OFF_FLAGS);
    wire sel_result = ~sel_mem & (AVS_ADDRESS_I == OFF_RESULT);
    wire sel_status = ~sel_mem & (AVS_ADDRESS_I == OFF_STATUS);
    wire [RW-1:0] bus_idx =
        AVS_ADDRESS_I[MEM_IDX_LO+RW-1:MEM_IDX_LO];
    wire bus_idx_ok = (32'(bus_idx) < DEPTH);

    wire [DW-1:0] be_mask = {
        {8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
        {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}
    };

    // Instruction fields.
    wire [5:0]    opc      = instr_reg[OPC_HI:OPC_LO];
    wire          eff_z    = instr_reg[EFF_Z];
    wire          eff_c    = instr_reg[EFF_C];
    wire          eff_r    = instr_reg[EFF_R];
    wire          eff_i    = instr_reg[EFF_I];
    wire [3:0]    cond     = instr_reg[COND_HI:COND_LO];
    wire [RW-1:0] dst_idx  = instr_reg[DST_HI:DST_LO];
    wire [RW-1:0] src_idx  = instr_reg[SRC_HI:SRC_LO];

    wire rotate_right_op      = (opc == OPC_ROT_RIGHT);
    wire rotate_left_op       = (opc == OPC_ROT_LEFT);
    wire arith_shift_right_op = (opc == OPC_ASHIFT_RIGHT);
    wire bit_reverse_op       = (opc == OPC_BIT_REVERSE);
    wire known                = rotate_right_op | rotate_left_op
                              | arith_shift_right_op | bit_reverse_op;

    // Condition field indexed by the current C and Z; 1111 always runs.
    wire cond_ok = cond[{c_reg, z_reg}];

    // Amount from literal or from register low five bits.
    wire [SW-1:0] amt = eff_i ? instr_reg[SW-1:0]
                              : sval_reg[SW-1:0];

    wire [DW-1:0] rot_res;
    wire [DW-1:0] bit_reverse_res;

    srr_rotator #(
        .W      (DW)
    ) u_rot (
        .val_i  (dval_reg),
        .amt_i  (amt),
        .left_i (rotate_left_op),
        .res_o  (rot_res)
    );

    srr_bit_reverse #(
        .W      (DW)
    ) u_bit_reverse (
        .val_i  (dval_reg),
        .amt_i  (amt),
        .res_o  (bit_reverse_res)
    );

    // Sign fill keeps two's-complement values divided by 2^amt.
    wire [DW-1:0] ashift_res =
        DW'($signed(dval_reg) >>> amt);

    wire [DW-1:0] op_res = bit_reverse_op       ? bit_reverse_res
                         : arith_shift_right_op ? ashift_res
                         : rot_res;

    wire          do_exec  = (state_reg == ST_EXEC) & known & cond_ok;
    wire          res_zero = (op_res == RST_WORD);
    wire          carry_in = rotate_left_op ? dval_reg[DW-1]
                                            : dval_reg[0];
    wire          exec_wr  = do_exec & eff_r;

    // Single write port shared by the bus and write-back.
    wire          bus_mem_we = wr_commit & sel_mem & bus_idx_ok;
    wire          mem_we     = exec_wr | bus_mem_we;
    wire [RW-1:0] mem_waddr  = exec_wr ? dst_idx : bus_idx;
    wire [DW-1:0] mem_old    = mem[bus_idx_ok ? bus_idx : '0];
    wire [DW-1:0] mem_wdata  = exec_wr ? op_res
        : (mem_old & ~be_mask) | (AVS_WRITEDATA_I & be_mask);

    wire [DW-1:0] flags_word = {{(DW-2){1'b0}}, c_reg, z_reg};
    wire [DW-1:0] status_word = {{(DW-4){1'b0}},
        wrote_reg, skip_reg, ill_reg, busy_reg};

    // Read data selection; unmapped addresses read as zero.
    always_comb begin
        rdata_next = RST_WORD;
        if (sel_mem) begin
            rdata_next = bus_idx_ok ? mem[bus_idx] : RST_WORD;
        end else if (sel_instr) begin
            rdata_next = instr_reg;
        end else if (sel_flags) begin
            rdata_next = flags_word;
        end else if (sel_result) begin
            rdata_next = result_reg;
        end else if (sel_status) begin
            rdata_next = status_word;
        end
    end

    // Sequencer: load operands, then execute and write back.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (wr_commit & sel_instr) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                state_next = ST_EXEC;
            end
            ST_EXEC: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign wait_next = ~bus_accept;

    assign instr_next = (wr_commit & sel_instr)
        ? (instr_reg & ~be_mask) | (AVS_WRITEDATA_I & be_mask)
        : instr_reg;

    // Flags: execution updates only the flags it is asked to write.
    always_comb begin
        z_next      = z_reg;
        c_next      = c_reg;
        result_next = result_reg;
        if (wr_commit & sel_flags & AVS_BYTEENABLE_I[0]) begin
            z_next = AVS_WRITEDATA_I[FLAG_Z];
            c_next = AVS_WRITEDATA_I[FLAG_C];
        end
        if (do_exec) begin
            result_next = op_res;
            if (eff_z) begin
                z_next = res_zero;
            end
            if (eff_c) begin
                c_next = carry_in;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state_reg <= ST_IDLE;
            wait_reg  <= 1'b1;
            rdata_reg <= RST_WORD;
            instr_reg <= RST_WORD;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg  <= wait_next;
            rdata_reg <= bus_accept ? rdata_next : rdata_reg;
            instr_reg <= instr_next;
            busy_reg  <= (state_next != ST_IDLE);
        end
    end

    // Operand fetch from the register memory.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            dval_reg <= RST_WORD;
            sval_reg <= RST_WORD;
        end else if (state_reg == ST_LOAD) begin
            dval_reg <= mem[dst_idx];
            sval_reg <= mem[src_idx];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            result_reg <= RST_WORD;
            z_reg      <= RST_FLAG;
            c_reg      <= RST_FLAG;
        end else begin
            result_reg <= result_next;
            z_reg      <= z_next;
            c_reg      <= c_next;
        end
    end

    // Outcome of the last instruction.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ill_reg   <= 1'b0;
            skip_reg  <= 1'b0;
            wrote_reg <= 1'b0;
        end else if (state_reg == ST_EXEC) begin
            ill_reg   <= ~known;
            skip_reg  <= known & ~cond_ok;
            wrote_reg <= exec_wr;
        end
    end

    assign AVS_READDATA_O    = rdata_reg;
    assign AVS_WAITREQUEST_O = wait_reg;
    assign ZERO_FLAG_O       = z_reg;
    assign CARRY_FLAG_O      = c_reg;
    assign BUSY_O            = busy_reg;

endmodule // srr_unit

// >>> dv/srr_unit_monitor.sv
// Concurrent checks on the ports of the shift and rotate unit.
// Bound into srr_unit; sees only its top-level ports.
module srr_unit_monitor
    import srr_pkg::*;
(
    input wire logic          CLK_I,             // Clock.
    input wire logic          NRST_I,            // Reset, low.
    input wire logic [AW-1:0] AVS_ADDRESS_I,     // Address.
    input wire logic          AVS_READ_I,        // Read.
    input wire logic          AVS_WRITE_I,       // Write.
    input wire logic [DW-1:0] AVS_READDATA_O,    // Read data.
    input wire logic          AVS_WAITREQUEST_O, // Stall.
    input wire logic          ZERO_FLAG_O,       // Z flag.
    input wire logic          CARRY_FLAG_O,      // C flag.
    input wire logic          BUSY_O             // Busy.
);
    timeunit 1ns;
    timeprecision 1ps;
    wire acc_w  = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    wire acc_r  = AVS_READ_I && !AVS_WAITREQUEST_O;
    wire fl_w   = acc_w && AVS_ADDRESS_I == OFF_FLAGS;
    wire req    = AVS_READ_I || AVS_WRITE_I;
    wire unmap  = !AVS_ADDRESS_I[MEM_SEL_BIT] && AVS_ADDRESS_I > OFF_STATUS;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    AST_WAIT_ONE:
        assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");
    AST_NO_SPURIOUS:
        assert property (!AVS_WAITREQUEST_O |-> $past(req))
        else $error("answer without a request");
    AST_BUSY_SPAN:
        assert property (acc_w && AVS_ADDRESS_I == OFF_INSTR
            |=> BUSY_O ##1 BUSY_O ##1 !BUSY_O)
        else $error("busy span after instruction is wrong");
    AST_BUSY_STALL:
        assert property (BUSY_O |-> AVS_WAITREQUEST_O)
        else $error("bus answered while busy");
    AST_ANSWER:
        assert property (req |-> ##[0:5] !AVS_WAITREQUEST_O)
        else $error("request not answered in time");
    AST_Z_HOLD:
        assert property ($changed(ZERO_FLAG_O) |-> $past(BUSY_O) || $past(fl_w))
        else $error("zero flag changed without cause");
    AST_C_HOLD:
        assert property ($changed(CARRY_FLAG_O) |-> $past(BUSY_O) || $past(fl_w))
        else $error("carry flag changed without cause");
    AST_FLAG_READ:
        assert property (acc_r && AVS_ADDRESS_I == OFF_FLAGS
            |-> AVS_READDATA_O == {30'h0, CARRY_FLAG_O, ZERO_FLAG_O})
        else $error("flags read back differ from flag ports");
    AST_UNMAPPED:
        assert property (acc_r && unmap |-> AVS_READDATA_O == 32'h0)
        else $error("unmapped read not zero");
    cover property (acc_w && AVS_ADDRESS_I == OFF_INSTR);
    cover property ($rose(ZERO_FLAG_O));
    cover property ($rose(CARRY_FLAG_O));
endmodule // srr_unit_monitor

bind srr_unit srr_unit_monitor u_mon (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .ZERO_FLAG_O(ZERO_FLAG_O), .CARRY_FLAG_O(CARRY_FLAG_O), .BUSY_O(BUSY_O)
);

// >>> dv/srr_seq_model.sv
// Instruction sequencer model: an Avalon-MM master issuing single words.
// Assumes a slave that holds waitrequest high until it answers.
module srr_seq_model
    import srr_pkg::*;
(
    input  wire logic          clk_i,  // Clock.
    input  wire logic          wait_i, // Slave stall.
    output logic      [AW-1:0] addr_o, // Byte address.
    output logic               rd_o,   // Read request.
    output logic               wr_o,   // Write request.
    output logic      [DW-1:0] data_o  // Write data.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o = 12'h000;
        data_o = 32'h0;
        rd_o = 1'b0;
        wr_o = 1'b0;
    end
    // Released address and data show the inverse so stale values never match.
    task automatic xfer(input logic w, input logic [AW-1:0] a,
                        input logic [DW-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        data_o <= d;
        wr_o <= w;
        rd_o <= !w;
        do @(posedge clk_i); while (wait_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        data_o <= ~d;
    endtask
endmodule // srr_seq_model

// >>> dv/tb_top.sv
// Self-checking bench for srr_unit with a scoreboard of read results.
// Assumes the sequencer model as bus master and the bound checker.
module tb_top
    import srr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clk = 1'b0;
    logic          nrst = 1'b0;
    logic [AW-1:0] addr;
    logic          rd, wr, wreq, zf, cf, busy, z_e, c_e;
    logic [DW-1:0] wdata, rdata, d, res;
    logic [DW-1:0] exp_q[$];
    logic [5:0]    op;
    logic [5:0]    ops[4] = '{OPC_ROT_RIGHT, OPC_ROT_LEFT,
                              OPC_ASHIFT_RIGHT, OPC_BIT_REVERSE};
    // Known operand, amount and result sets, one per operation above.
    logic [DW-1:0] vec_d[4] = '{32'h1234_5678, 32'h8765_4321,
                                32'hFFFF_FF9C, 32'h8421_DECA};
    logic [SW-1:0] vec_n[4] = '{5'h04, 5'h04, 5'h03, 5'h1C};
    logic [DW-1:0] vec_r[4] = '{32'h8123_4567, 32'h7654_3218,
                                32'hFFFF_FFF3, 32'h0000_0005};
    logic [SW-1:0] n;
    logic [3:0]    f;
    logic [RW-1:0] dst, src;
    int            miscompares = 0;
    int            checked = 0;

    always #2 clk = ~clk;

    srr_unit DUT (.CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .ZERO_FLAG_O(zf), .CARRY_FLAG_O(cf),
        .BUSY_O(busy));
    srr_seq_model u_seq (.clk_i(clk), .wait_i(wreq), .addr_o(addr),
        .rd_o(rd), .wr_o(wr), .data_o(wdata));

    task automatic chk(string nm, logic [DW-1:0] seen, logic [DW-1:0] e);
        checked++;
        if (seen !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic finish_test();
        $display("Checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic rdx(logic [AW-1:0] a, logic [DW-1:0] e);
        exp_q.push_back(e);
        u_seq.xfer(1'b0, a, 32'h0);
    endtask
    function automatic logic [AW-1:0] mem(logic [RW-1:0] i);
        return {1'b1, i, 2'b00};
    endfunction
    function automatic logic [DW-1:0] ref_op(logic [5:0] o, logic [DW-1:0] v,
                                            logic [SW-1:0] s);
        logic [63:0] t, u;
        logic [DW-1:0] r;
        t = {v, v} >> s;
        u = {v, v} << s;
        r = {<<{v}};
        case (o)
            OPC_ROT_RIGHT:    ref_op = t[31:0];
            OPC_ROT_LEFT:     ref_op = u[63:32];
            OPC_ASHIFT_RIGHT: ref_op = $signed(v) >>> s;
            default: ref_op = r >> s;
        endcase
    endfunction

    always @(posedge clk) begin
        if (rd && !wreq)
            chk("readdata", rdata, exp_q.pop_front());
    end

    initial begin
        #40000;
        $display("Error watchdog expected done seen timeout");
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(32'haea7c96d));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rdx(OFF_FLAGS, 32'h0);
        u_seq.xfer(1'b1, 12'h010, 32'hFFFF_FFFF);
        rdx(12'h010, 32'h0);
        u_seq.xfer(1'b1, OFF_FLAGS, 32'h3);
        {c_e, z_e} = 2'b11;
        rdx(OFF_FLAGS, 32'h3);
        $display("Test flags and map done");
        for (int k = 0; k < 48; k++) begin
            op = ops[k % 4];
            d = (k % 7 == 0) ? 32'h0 : $urandom;
            n = (k < 12) ? ((k < 8) ? 5'h00 : 5'h1F) : 5'($urandom);
            f = 4'($urandom);
            dst = 9'($urandom);
            src = dst ^ 9'h001;
            res = ref_op(op, d, n);
            if (k < 4) begin
                d   = vec_d[k];
                n   = vec_n[k];
                res = vec_r[k];
            end
            u_seq.xfer(1'b1, mem(dst), d);
            u_seq.xfer(1'b1, mem(src), {27'($urandom), n});
            u_seq.xfer(1'b1, OFF_INSTR, {op, f, COND_ALWAYS, dst,
                f[0] ? {4'h0, n} : src});
            if (f[3])
                z_e = (res == 32'h0);
            if (f[2])
                c_e = (op == OPC_ROT_LEFT) ? d[31] : d[0];
            rdx(mem(dst), f[1] ? res : d);
            rdx(OFF_RESULT, res);
            rdx(OFF_RESULT, res);
            rdx(OFF_FLAGS, {30'h0, c_e, z_e});
            rdx(OFF_STATUS, {28'h0, f[1], 3'h0});
            chk("flag_ports", {30'h0, cf, zf}, {30'h0, c_e, z_e});
        end
        $display("Test random operations done");
        u_seq.xfer(1'b1, OFF_INSTR, {OPC_ROT_LEFT, 4'hE, 4'h0, dst, src});
        rdx(OFF_STATUS, 32'h0000_0004);
        rdx(OFF_RESULT, res);
        u_seq.xfer(1'b1, OFF_INSTR, {6'h3F, 4'hE, COND_ALWAYS, dst, src});
        rdx(OFF_STATUS, 32'h0000_0002);
        rdx(OFF_FLAGS, {30'h0, c_e, z_e});
        $display("Test skipped and unknown instructions done");
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rdx(OFF_FLAGS, 32'h0);
        rdx(OFF_RESULT, 32'h0);
        chk("reset_flags", {30'h0, cf, zf}, 32'h0);
        $display("Test mid-run reset done");
        @(posedge clk);
        chk("pending_reads", 32'(exp_q.size()), 32'h0);
        finish_test();
    end
endmodule // tb_top
